// [src/bsr_defines.vh]
`ifndef BSR_DEFINES_VH
`define BSR_DEFINES_VH
// Register lengths
`define BSR_IR_LEN 3
`define BSR_ID_LEN 32
`define BSR_BND_LEN 109
// Boundary cell tied to ground, counted from 1
`define BSR_GND_CELL 64
// Instruction codes
`define BSR_IR_EXTEST 3'h0
`define BSR_IR_IDCODE 3'h1
`define BSR_IR_SAMPLEZ 3'h2
`define BSR_IR_SAMPLE 3'h4
`define BSR_IR_BYPASS 3'h7
// Identification word defaults, values arbitrary
`define BSR_ID_REV 4'h0
`define BSR_ID_PART 16'h1234
`define BSR_ID_MAKER 11'h2aa
// Mode-select-high edges that force test-logic-reset
`define BSR_TLR_EDGES 5
`endif

// [src/bsr_sync.v]
`timescale 1ns/100ps
// Two-stage synchroniser with rise and fall pulses
module bsr_sync (
  input wire clk_i, // System clock
  input wire rstn_i, // Async reset, active low
  input wire d_i, // Asynchronous input
  output reg q_o, // Synchronised level
  output wire rise_o, // One-cycle rise pulse
  output wire fall_o // One-cycle fall pulse
);
  reg s1_q;
  reg s2_q;

  // Two flops, then an edge register
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      q_o <= 1'b0;
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
      q_o <= s2_q;
    end
  end

  assign rise_o = s2_q & ~q_o;
  assign fall_o = ~s2_q & q_o;
endmodule // bsr_sync

// [src/bsr_tap.v]
// Function
// - Instruction register is three bits
// - Bypass path is one stage
// - Identification register is 32 bits
// - Boundary register has 109 cells
// - Id bits hold revision and part number
// - Id bits 11..1 hold maker code
// - Id bit 0 always one
// - Ground cell 64 always reads low
// - Id word loaded in capture-DR
// - Reset loads identification instruction
// - Five high mode-select edges reset
// - Serial output changes on falling edge
`timescale 1ns/100ps
`include "bsr_defines.vh"
module bsr_tap #(
  parameter IR_LEN = `BSR_IR_LEN, // Instruction length
  parameter BND_LEN = `BSR_BND_LEN, // Boundary length
  parameter [3:0] ID_REV = `BSR_ID_REV, // Revision, arbitrary
  parameter [15:0] ID_PART = `BSR_ID_PART, // Part code, arbitrary
  parameter [10:0] ID_MAKER = `BSR_ID_MAKER // Maker code, arbitrary
) (
  input wire clk_i, // System clock, 10 MHz
  input wire rstn_i, // Async reset, active low
  input wire tck_i, // Test clock pin
  input wire tms_i, // Mode select pin
  input wire tdi_i, // Serial data in pin
  input wire [BND_LEN-1:0] pins_i, // I/O ring values to capture
  output reg tdo_o, // Serial data out
  output reg tdo_oe_n_o, // Output enable, low drives
  output reg [IR_LEN-1:0] instr_o, // Current instruction
  output reg [BND_LEN-1:0] bnd_upd_o, // Boundary update latch
  output reg tlr_o // In test-logic-reset
);
  // One-hot TAP states
  localparam [15:0] S_TLR = 16'h0001;
  localparam [15:0] S_RTI = 16'h0002;
  localparam [15:0] S_SDR = 16'h0004;
  localparam [15:0] S_CDR = 16'h0008;
  localparam [15:0] S_SHD = 16'h0010;
  localparam [15:0] S_E1D = 16'h0020;
  localparam [15:0] S_PDR = 16'h0040;
  localparam [15:0] S_E2D = 16'h0080;
  localparam [15:0] S_UDR = 16'h0100;
  localparam [15:0] S_SIR = 16'h0200;
  localparam [15:0] S_CIR = 16'h0400;
  localparam [15:0] S_SHI = 16'h0800;
  localparam [15:0] S_E1I = 16'h1000;
  localparam [15:0] S_PIR = 16'h2000;
  localparam [15:0] S_E2I = 16'h4000;
  localparam [15:0] S_UIR = 16'h8000;
  localparam GND_IDX = `BSR_GND_CELL - 1;

  wire tck_s;
  wire tck_rise;
  wire tck_fall;
  wire tms_s;
  wire tdi_s;
  reg [15:0] st_q;
  reg [15:0] st_d;
  reg [2:0] tms_cnt_q;
  reg [IR_LEN-1:0] ir_q;
  reg bypass_q;
  reg [31:0] id_q;
  reg [BND_LEN-1:0] bnd_q;
  reg [BND_LEN-1:0] cap_v;
  reg tdo_d;
  reg [1:0] sel_q;
  reg sh_q;

  // Test clock edges found by the system clock
  bsr_sync u_tck (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .d_i(tck_i),
    .q_o(tck_s),
    .rise_o(tck_rise),
    .fall_o(tck_fall)
  );

  // Mode select and data in, aligned with the clock sampler
  bsr_sync u_tms (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .d_i(tms_i),
    .q_o(tms_s),
    .rise_o(),
    .fall_o()
  );

  bsr_sync u_tdi (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .d_i(tdi_i),
    .q_o(tdi_s),
    .rise_o(),
    .fall_o()
  );

  // Next TAP state
  always @* begin
    case (st_q)
      S_TLR: st_d = tms_s ? S_TLR : S_RTI;
      S_RTI: st_d = tms_s ? S_SDR : S_RTI;
      S_SDR: st_d = tms_s ? S_SIR : S_CDR;
      S_CDR: st_d = tms_s ? S_E1D : S_SHD;
      S_SHD: st_d = tms_s ? S_E1D : S_SHD;
      S_E1D: st_d = tms_s ? S_UDR : S_PDR;
      S_PDR: st_d = tms_s ? S_E2D : S_PDR;
      S_E2D: st_d = tms_s ? S_UDR : S_SHD;
      S_UDR: st_d = tms_s ? S_SDR : S_RTI;
      S_SIR: st_d = tms_s ? S_TLR : S_CIR;
      S_CIR: st_d = tms_s ? S_E1I : S_SHI;
      S_SHI: st_d = tms_s ? S_E1I : S_SHI;
      S_E1I: st_d = tms_s ? S_UIR : S_PIR;
      S_PIR: st_d = tms_s ? S_E2I : S_PIR;
      S_E2I: st_d = tms_s ? S_UIR : S_SHI;
      S_UIR: st_d = tms_s ? S_SDR : S_RTI;
      default: st_d = S_TLR;
    endcase
    if (tms_s && tms_cnt_q == 3'h4) begin
      st_d = S_TLR;
    end
  end

  // Boundary capture value with the ground cell forced low
  always @* begin
    cap_v = pins_i;
    cap_v[GND_IDX] = 1'b0;
  end

  // State, counters and shift registers on test clock rise
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q <= S_TLR;
      tms_cnt_q <= 3'h0;
      ir_q <= `BSR_IR_IDCODE;
      instr_o <= `BSR_IR_IDCODE;
      bypass_q <= 1'b0;
      id_q <= 32'h0;
      bnd_q <= {BND_LEN{1'b0}};
      bnd_upd_o <= {BND_LEN{1'b0}};
      tlr_o <= 1'b1;
    end else if (tck_rise) begin
      st_q <= st_d;
      tlr_o <= (st_d == S_TLR);
      if (!tms_s) begin
        tms_cnt_q <= 3'h0;
      end else if (tms_cnt_q != 3'h4) begin
        tms_cnt_q <= tms_cnt_q + 3'h1;
      end
      case (st_q)
        S_TLR: begin
          instr_o <= `BSR_IR_IDCODE;
        end
        S_CIR: begin
          ir_q <= {{(IR_LEN-1){1'b0}}, 1'b1};
        end
        S_SHI: begin
          ir_q <= {tdi_s, ir_q[IR_LEN-1:1]};
        end
        S_UIR: begin
          instr_o <= ir_q;
        end
        S_CDR: begin
          bypass_q <= 1'b0;
          if (instr_o == `BSR_IR_IDCODE) begin
            id_q[31:28] <= ID_REV;
            id_q[27:12] <= ID_PART;
            id_q[11:1] <= ID_MAKER;
            id_q[0] <= 1'b1;
          end
          if (instr_o != `BSR_IR_BYPASS && instr_o != `BSR_IR_IDCODE) begin
            bnd_q <= cap_v;
          end
        end
        S_SHD: begin
          bypass_q <= tdi_s;
          id_q <= {tdi_s, id_q[31:1]};
          bnd_q <= {tdi_s, bnd_q[BND_LEN-1:1]};
        end
        S_UDR: begin
          if (instr_o == `BSR_IR_EXTEST || instr_o == `BSR_IR_SAMPLE) begin
            bnd_upd_o <= bnd_q;
            bnd_upd_o[GND_IDX] <= 1'b0;
          end
        end
        default: begin
        end
      endcase
      if (st_d == S_TLR) begin
        ir_q <= `BSR_IR_IDCODE;
        instr_o <= `BSR_IR_IDCODE;
      end
    end
  end

  // Path select and shift flag, sampled at rise for the fall update
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sel_q <= 2'h0;
      sh_q <= 1'b0;
    end else if (tck_rise) begin
      sh_q <= (st_d == S_SHD) || (st_d == S_SHI);
      if (st_d == S_SHI || st_d == S_E1I || st_d == S_PIR ||
          st_d == S_E2I) begin
        sel_q <= 2'h0;
      end else if (instr_o == `BSR_IR_IDCODE) begin
        sel_q <= 2'h1;
      end else if (instr_o == `BSR_IR_BYPASS || instr_o == 3'h3 ||
                   instr_o == 3'h5 || instr_o == 3'h6) begin
        sel_q <= 2'h2;
      end else begin
        sel_q <= 2'h3;
      end
    end
  end

  // Serial output mux
  always @* begin
    case (sel_q)
      2'h0: tdo_d = ir_q[0];
      2'h1: tdo_d = id_q[0];
      2'h2: tdo_d = bypass_q;
      default: tdo_d = bnd_q[0];
    endcase
  end

  // Serial output updated on test clock fall
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tdo_o <= 1'b0;
      tdo_oe_n_o <= 1'b1;
    end else if (tck_fall) begin
      tdo_o <= tdo_d;
      tdo_oe_n_o <= ~sh_q;
    end
  end
endmodule // bsr_tap

// [verif/bsr_tap_asserts.sv]
`timescale 1ns/100ps
module bsr_tap_asserts #(
  parameter IR_LEN = 3,
  parameter BND_LEN = 109
) (
  input wire clk_i, // System clock
  input wire rstn_i, // Async reset
  input wire tck_i, // Test clock
  input wire tms_i, // Mode select
  input wire tdi_i, // Serial in
  input wire [BND_LEN-1:0] pins_i, // Ring values
  input wire tdo_o, // Serial out
  input wire tdo_oe_n_o, // Output enable
  input wire [IR_LEN-1:0] instr_o, // Instruction
  input wire [BND_LEN-1:0] bnd_upd_o, // Update latch
  input wire tlr_o // Test-logic-reset
);
  logic tck_q;
  logic [2:0] hi_cnt_q;
  wire rise = tck_i && !tck_q;
  // Count test clock rises with mode select high
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tck_q <= 1'b0;
      hi_cnt_q <= 3'h0;
    end else begin
      tck_q <= tck_i;
      if (rise) begin
        hi_cnt_q <= !tms_i ? 3'h0 :
          (hi_cnt_q == 3'h5 ? 3'h5 : hi_cnt_q + 3'h1);
      end
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  AST_TLR_ENTER: assert property (hi_cnt_q == 3'h5 |-> ##[0:8] tlr_o)
    else $error("reset state not reached");
  AST_TLR_STAY: assert property (
    rise && tms_i && tlr_o |-> tlr_o[*8])
    else $error("reset state left with mode high");
  AST_TLR_LEAVE: assert property (
    rise && !tms_i && tlr_o |-> ##[1:8] !tlr_o)
    else $error("reset state not left");
  AST_INSTR_TLR: assert property (tlr_o[*3] |-> instr_o == 3'h1)
    else $error("instruction not identification");
  AST_TDO_STABLE: assert property (rise |-> $stable(tdo_o)[*4])
    else $error("serial out moved near rise");
  AST_OE_TLR: assert property (tlr_o |-> tdo_oe_n_o)
    else $error("serial out driven in reset state");
  AST_BND_HOLD: assert property (
    $changed(bnd_upd_o) |-> instr_o == 3'h0 || instr_o == 3'h4)
    else $error("update latch changed");
  AST_GND_CELL: assert property (bnd_upd_o[63] == 1'b0)
    else $error("ground cell not low");
  cover property ($rose(tlr_o));
  cover property (instr_o == 3'h7);
  cover property ($fell(tdo_oe_n_o));
endmodule // bsr_tap_asserts

bind bsr_tap bsr_tap_asserts #(.IR_LEN(IR_LEN), .BND_LEN(BND_LEN))
  u_bsr_tap_asserts (
  .clk_i(clk_i), .rstn_i(rstn_i), .tck_i(tck_i), .tms_i(tms_i), .tdi_i(tdi_i),
  .pins_i(pins_i), .tdo_o(tdo_o), .tdo_oe_n_o(tdo_oe_n_o), .instr_o(instr_o),
  .bnd_upd_o(bnd_upd_o), .tlr_o(tlr_o));

// [verif/bsr_ctl_model.sv]
`timescale 1ns/100ps
module bsr_ctl_model (
  input wire clk_i, // System clock
  output logic tck_o = 1'b0, // Test clock, idle low
  output logic tms_o = 1'b1, // Mode select
  output logic tdi_o = 1'b0, // Serial data out to device
  input wire tdo_i // Serial data from device
);
  // One test clock period, eight system clocks a phase
  task step(input logic t, input logic di, output logic o);
    tms_o <= t;
    tdi_o <= di;
    repeat (8) @(posedge clk_i);
    o = tdo_i;
    tck_o <= 1'b1;
    repeat (8) @(posedge clk_i);
    tck_o <= 1'b0;
  endtask
  // Mode select high over five rises and more
  task reset5;
    logic o;
    repeat (6) step(1'b1, 1'b0, o);
  endtask
  // Walk to a shift state, move n bits, back to idle
  task scan(input logic ir, input int n, input logic [127:0] din,
            output logic [127:0] dout);
    logic o;
    dout = '0;
    step(1'b0, 1'b0, o);
    step(1'b1, 1'b0, o);
    if (ir) step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    step(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
    step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
  endtask
endmodule // bsr_ctl_model

// [verif/bsr_tap_tb_top.sv]
`timescale 1ns/100ps
`include "bsr_defines.vh"
module bsr_tap_tb_top;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [108:0] pins_i = '0;
  logic [108:0] e;
  logic [127:0] d;
  wire tck, tms, tdi, tdo_o, tdo_oe_n_o, tlr_o;
  wire [2:0] instr_o;
  wire [108:0] bnd_upd_o;
  int err_count = 0;
  int checks_done = 0;
  // System clock
  always #50 clk_i = ~clk_i;
  bsr_tap u_bsr_tap (.clk_i(clk_i), .rstn_i(rstn_i), .tck_i(tck), .tms_i(tms),
    .tdi_i(tdi), .pins_i(pins_i), .tdo_o(tdo_o), .tdo_oe_n_o(tdo_oe_n_o),
    .instr_o(instr_o), .bnd_upd_o(bnd_upd_o), .tlr_o(tlr_o));
  bsr_ctl_model u_bsr_ctl_model (.clk_i(clk_i), .tck_o(tck), .tms_o(tms),
    .tdi_o(tdi), .tdo_i(tdo_o));
  task chk(input string nm, input logic [127:0] ex, input logic [127:0] got);
    checks_done++;
    if (got !== ex) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task summarize;
    $display("mismatches %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task t_idcode;
    chk("instr_rst", 3'h1, instr_o);
    chk("tlr_rst", 1'b1, tlr_o);
    chk("oe_rst", 1'b1, tdo_oe_n_o);
    u_bsr_ctl_model.scan(1'b0, 33, 128'h1, d);
    chk("id", {`BSR_ID_REV, `BSR_ID_PART, `BSR_ID_MAKER, 1'b1},
      d[31:0]);
    chk("oe_idle", 1'b1, tdo_oe_n_o);
    chk("id_len", 1'b1, d[32]);
  endtask
  task t_bypass;
    u_bsr_ctl_model.scan(1'b1, 4, 128'hf, d);
    chk("ir_cap", 3'h1, d[2:0]);
    chk("ir_len", 1'b1, d[3]);
    chk("instr", 3'h7, instr_o);
    u_bsr_ctl_model.scan(1'b0, 2, 128'h1, d);
    chk("byp_cap", 1'b0, d[0]);
    chk("byp_len", 1'b1, d[1]);
    u_bsr_ctl_model.reset5();
    chk("instr_tlr", 3'h1, instr_o);
    chk("tlr", 1'b1, tlr_o);
  endtask
  task t_sample;
    @(posedge clk_i) pins_i <= {1'b1, {54{2'b10}}};
    u_bsr_ctl_model.scan(1'b1, 3, 128'h4, d);
    u_bsr_ctl_model.scan(1'b0, 110, 128'h1, d);
    e = {1'b1, {54{2'b10}}};
    e[63] = 1'b0;
    chk("bnd", e, d[108:0]);
    chk("bnd_len", 1'b1, d[109]);
  endtask
  // Boundary update under the test instruction, then a mid-run reset
  task t_extest;
    u_bsr_ctl_model.scan(1'b1, 3, 128'h0, d);
    chk("ir_cap2", 3'h1, d[2:0]);
    chk("instr_ext", 3'h0, instr_o);
    u_bsr_ctl_model.scan(1'b0, 110, {128{1'b1}}, d);
    e = {1'b1, {54{2'b10}}};
    e[63] = 1'b0;
    chk("bnd_ext", e, d[108:0]);
    chk("bnd_len_ext", 1'b1, d[109]);
    e = {109{1'b1}};
    e[63] = 1'b0;
    chk("upd_ext", e, bnd_upd_o);
    @(posedge clk_i) rstn_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk("upd_rst", 109'h0, bnd_upd_o);
    chk("instr_rst2", 3'h1, instr_o);
    chk("tlr_rst2", 1'b1, tlr_o);
    u_bsr_ctl_model.scan(1'b0, 33, 128'h1, d);
    chk("id_rst2", {`BSR_ID_REV, `BSR_ID_PART, `BSR_ID_MAKER, 1'b1},
      d[31:0]);
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    t_idcode();
    t_bypass();
    t_sample();
    t_extest();
    summarize();
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    summarize();
  end
endmodule // bsr_tap_tb_top
